// *** common/rsfe_pkg.sv ***
// constants shared by the remote serial front end
package rsfe_pkg;
	localparam int          DATA_BITS   = 8;
	localparam int          OVS         = 16;
	localparam logic [3:0]  OVS_LAST    = 4'hF;
	localparam logic [3:0]  OVS_MID     = 4'h7;
	localparam logic [2:0]  BIT_LAST    = 3'h7;
	localparam logic [3:0]  FRAME_LAST  = 4'h9;
	localparam int          DIV_W       = 16;
	localparam int          ADDR_W      = 5;
	localparam logic [4:0]  PBUS_BAD    = 5'h1F;
	localparam logic [7:0]  MSB_CLEAR   = 8'h7F;
	localparam logic [7:0]  PRINT_MIN   = 8'h20;
	localparam logic [7:0]  CASE_BIT    = 8'h20;
	localparam logic [7:0]  LOWER_A     = 8'h61;
	localparam logic [7:0]  LOWER_Z     = 8'h7A;
	localparam logic [7:0]  C_SET_ADDR  = 8'h02;
	localparam logic [7:0]  C_UNADDR    = 8'h03;
	localparam logic [7:0]  C_LOCK      = 8'h04;
	localparam logic [7:0]  C_ACK       = 8'h06;
	localparam logic [7:0]  C_LF        = 8'h0A;
	localparam logic [7:0]  C_XON       = 8'h11;
	localparam logic [7:0]  C_LISTEN    = 8'h12;
	localparam logic [7:0]  C_XOFF      = 8'h13;
	localparam logic [7:0]  C_TALK      = 8'h14;
	localparam logic [7:0]  C_CLEAR     = 8'h18;
	localparam logic [9:0]  TX_IDLE     = 10'h3FF;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rsfe_rx_e;
endpackage

// *** hdl/rsfe_buf.sv ***
// two-entry buffer between receiver and command consumer
`timescale 1ns/1ps
module rsfe_buf #(
	parameter int DW = 8
) (
	// clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_arst_n,
	// fill side
	input  wire logic          i_valid,
	input  wire logic [DW-1:0] i_data,
	output logic               o_ready,
	// drain side
	output logic               o_valid,
	output logic [DW-1:0]      o_data,
	input  wire logic          i_ready
);
	logic [DW-1:0] mem_q [2];
	logic          wp_q;
	logic          rp_q;
	logic [1:0]    cnt_q;
	wire           push = i_valid & o_ready;
	wire           pop  = o_valid & i_ready;

	assign o_ready = (cnt_q != 2'h2);
	assign o_valid = (cnt_q != 2'h0);
	assign o_data  = mem_q[rp_q];

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			wp_q     <= 1'b0;
			rp_q     <= 1'b0;
			cnt_q    <= 2'h0;
			mem_q[0] <= '0;
			mem_q[1] <= '0;
		end
		else
		begin
			if (push)
			begin
				mem_q[wp_q] <= i_data;
				wp_q        <= ~wp_q;
			end
			if (pop)
				rp_q <= ~rp_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

// *** hdl/rsfe_top.sv ***
// serial remote front end: receiver, addressing, flow control, sender
`timescale 1ns/1ps
module rsfe_top (
	// clock and reset
	input  wire logic                        I_CORE_CLK,
	input  wire logic                        I_ARST_N,
	// serial pins, upstream side
	input  wire logic                        I_RXD,
	output logic                             O_TXD,
	// serial pins, downstream side
	input  wire logic                        I_SECONDARY_SERIAL_IN,
	output logic                             O_SECONDARY_SERIAL_OUT,
	// stored configuration
	input  wire logic                        I_IF_SERIAL,
	input  wire logic [rsfe_pkg::ADDR_W-1:0] I_DEV_ADDR,
	input  wire logic [rsfe_pkg::DIV_W-1:0]  I_OVS_DIV,
	// front panel
	input  wire logic                        I_LOCAL_KEY,
	output logic                             O_REMOTE_INDICATOR,
	output logic                             O_KEYPAD_EN,
	output logic                             O_ADDR_OK,
	// command text stream
	output logic                             O_CMD_VALID,
	output logic [7:0]                       O_CMD_DATA,
	input  wire logic                        I_CMD_READY,
	output logic                             O_CMD_END,
	// response stream
	input  wire logic                        I_RSP_VALID,
	input  wire logic [7:0]                  I_RSP_DATA,
	output logic                             O_RSP_READY
);
	import rsfe_pkg::*;

	// upper-case fold for keyword matching
	function automatic logic [7:0] fold(input logic [7:0] c);
		if (c >= LOWER_A && c <= LOWER_Z)
			fold = c & ~CASE_BIT;
		else
			fold = c;
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [1:0] rx_sync_q;
	logic [1:0] sec_sync_q;
	logic [1:0] key_sync_q;
	logic       key_old_q;
	wire        rx_pin  = rx_sync_q[1];
	wire        sec_pin = sec_sync_q[1];
	wire        key_hit = key_sync_q[1] & ~key_old_q;

	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			rx_sync_q  <= 2'h3;
			sec_sync_q <= 2'h3;
			key_sync_q <= 2'h0;
			key_old_q  <= 1'b0;
		end
		else
		begin
			rx_sync_q  <= {rx_sync_q[0], I_RXD};
			sec_sync_q <= {sec_sync_q[0], I_SECONDARY_SERIAL_IN};
			key_sync_q <= {key_sync_q[0], I_LOCAL_KEY};
			key_old_q  <= key_sync_q[1];
		end
	end

	// ----------------------------------------
	// oversampling tick
	// ----------------------------------------
	logic [DIV_W-1:0] div_q;
	wire              tick = (div_q == '0);

	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			div_q <= '0;
		else if (tick)
			div_q <= I_OVS_DIV;
		else
			div_q <= div_q - 1'b1;
	end

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	rsfe_rx_e   rx_st_q;
	logic [3:0] rx_cnt_q;
	logic [2:0] rx_bit_q;
	logic [7:0] rx_sh_q;
	logic       rx_done_q;
	logic [7:0] rx_byte_q;
	wire        cell_end = tick & (rx_cnt_q == OVS_LAST);

	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			rx_st_q   <= RX_IDLE;
			rx_cnt_q  <= 4'h0;
			rx_bit_q  <= 3'h0;
			rx_sh_q   <= 8'h00;
			rx_done_q <= 1'b0;
			rx_byte_q <= 8'h00;
		end
		else
		begin
			rx_done_q <= 1'b0;
			if (tick)
				rx_cnt_q <= rx_cnt_q + 4'h1;
			case (rx_st_q)
				RX_IDLE:
					if (tick && !rx_pin)
					begin
						rx_st_q  <= RX_START;
						rx_cnt_q <= 4'h0;
					end
				RX_START:
					// start-bit centre; a glitch returns to idle
					if (tick && rx_cnt_q == OVS_MID)
					begin
						rx_st_q  <= rx_pin ? RX_IDLE : RX_DATA;
						rx_cnt_q <= 4'h0;
						rx_bit_q <= 3'h0;
					end
				RX_DATA:
					if (cell_end)
					begin
						rx_sh_q  <= {rx_pin, rx_sh_q[7:1]};
						rx_bit_q <= rx_bit_q + 3'h1;
						if (rx_bit_q == BIT_LAST)
							rx_st_q <= RX_STOP;
					end
				RX_STOP:
					if (cell_end)
					begin
						rx_st_q   <= RX_IDLE;
						rx_done_q <= rx_pin;
						rx_byte_q <= rx_sh_q & MSB_CLEAR;
					end
				default:
					rx_st_q <= RX_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// character decode
	// ----------------------------------------
	logic addr_en_q;
	logic locked_q;
	logic listen_q;
	logic talk_q;
	logic pend_lsn_q;
	logic pend_tlk_q;
	logic pause_q;
	logic ack_q;
	logic remote_q;

	wire rx_ok     = rx_done_q & I_IF_SERIAL;
	wire is_text   = (rx_byte_q >= PRINT_MIN);
	wire addrable  = addr_en_q & ~locked_q;
	wire pending   = addrable & (pend_lsn_q | pend_tlk_q);
	wire is_me     = (rx_byte_q[ADDR_W-1:0] == I_DEV_ADDR);
	wire lsn_match = rx_ok & addrable & pend_lsn_q & is_me;
	wire may_hear  = ~addrable | listen_q;
	wire accept    = rx_ok & ~pending & is_text & may_hear;
	wire end_seen  = rx_ok & ~pending & (rx_byte_q == C_LF) & may_hear;
	wire may_talk  = ~addrable | talk_q;
	wire [7:0] cmd_char = fold(rx_byte_q);

	// ----------------------------------------
	// addressing state
	// ----------------------------------------
	logic ack_take;
	logic talk_done;

	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			addr_en_q  <= 1'b0;
			locked_q   <= 1'b0;
			listen_q   <= 1'b0;
			talk_q     <= 1'b0;
			pend_lsn_q <= 1'b0;
			pend_tlk_q <= 1'b0;
			pause_q    <= 1'b0;
		end
		else
		begin
			if (talk_done)
				talk_q <= 1'b0;
			if (rx_ok && rx_byte_q == C_XOFF)
				pause_q <= 1'b1;
			else if (rx_ok && rx_byte_q == C_XON)
				pause_q <= 1'b0;
			if (rx_ok && !addrable)
			begin
				if (rx_byte_q == C_LOCK)
					locked_q <= 1'b1;
				else if (rx_byte_q == C_SET_ADDR && !locked_q)
					addr_en_q <= 1'b1;
			end
			else if (rx_ok && pending)
			begin
				pend_lsn_q <= 1'b0;
				pend_tlk_q <= 1'b0;
				if (pend_lsn_q)
					listen_q <= is_me;
				else
					talk_q <= is_me;
			end
			else if (rx_ok)
			begin
				case (rx_byte_q)
					C_LISTEN:
					begin
						pend_lsn_q <= 1'b1;
						talk_q     <= 1'b0;
					end
					C_TALK:
					begin
						pend_tlk_q <= 1'b1;
						listen_q   <= 1'b0;
					end
					C_UNADDR, C_CLEAR:
					begin
						listen_q <= 1'b0;
						talk_q   <= 1'b0;
					end
					C_LOCK:
					begin
						locked_q <= 1'b1;
						listen_q <= 1'b0;
						talk_q   <= 1'b0;
					end
					default:
						listen_q <= listen_q;
				endcase
			end
		end
	end

	// ----------------------------------------
	// remote / local state
	// ----------------------------------------
	// setting wins over the local key; keypad follows the same next value
	wire remote_d = lsn_match | accept | (remote_q & ~key_hit);
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			remote_q    <= 1'b0;
			O_KEYPAD_EN <= 1'b1;
			ack_q       <= 1'b0;
		end
		else
		begin
			remote_q    <= remote_d;
			O_KEYPAD_EN <= ~remote_d;
			ack_q       <= lsn_match | (ack_q & ~ack_take);
		end
	end

	assign O_REMOTE_INDICATOR = remote_q;
	assign O_ADDR_OK = I_IF_SERIAL | (I_DEV_ADDR != PBUS_BAD);

	// ----------------------------------------
	// command buffer
	// ----------------------------------------
	logic buf_ready;

	rsfe_buf #(
		.DW       (DATA_BITS)
	) u_buf (
		.i_clk    (I_CORE_CLK),
		.i_arst_n (I_ARST_N),
		.i_valid  (accept),
		.i_data   (cmd_char),
		.o_ready  (buf_ready),
		.o_valid  (O_CMD_VALID),
		.o_data   (O_CMD_DATA),
		.i_ready  (I_CMD_READY)
	);

	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			O_CMD_END <= 1'b0;
		else
			O_CMD_END <= end_seen;
	end

	// ----------------------------------------
	// transmitter and flow control
	// ----------------------------------------
	logic [9:0] tx_sh_q;
	logic [3:0] tx_cnt_q;
	logic [3:0] tx_bit_q;
	logic       tx_busy_q;
	logic       xoff_sent_q;
	logic       tx_lf_q;

	// xoff as soon as the buffer is full, since one more word would be lost
	wire need_xoff = ~buf_ready & ~xoff_sent_q;
	wire need_xon  = xoff_sent_q & ~O_CMD_VALID;
	wire tx_free   = ~tx_busy_q;
	wire send_ctl  = tx_free & (need_xoff | need_xon);
	wire send_ack  = tx_free & ~need_xoff & ~need_xon & ack_q;
	wire rsp_slot  = tx_free & ~need_xoff & ~need_xon & ~ack_q;
	wire rsp_go    = rsp_slot & may_talk & ~pause_q;
	wire [7:0] ctl_char = need_xoff ? C_XOFF : C_XON;
	wire [7:0] tx_char  = send_ctl ? ctl_char : (send_ack ? C_ACK : I_RSP_DATA);
	wire tx_load   = send_ctl | send_ack | (rsp_go & I_RSP_VALID);

	assign O_RSP_READY = rsp_go;
	assign ack_take    = send_ack;
	assign talk_done   = tx_busy_q & tx_lf_q & (tx_bit_q == FRAME_LAST) & tick
		& (tx_cnt_q == OVS_LAST) & addrable;

	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			tx_sh_q     <= TX_IDLE;
			tx_cnt_q    <= 4'h0;
			tx_bit_q    <= 4'h0;
			tx_busy_q   <= 1'b0;
			xoff_sent_q <= 1'b0;
			tx_lf_q     <= 1'b0;
		end
		else if (tx_load)
		begin
			tx_sh_q   <= {1'b1, tx_char, 1'b0};
			tx_cnt_q  <= 4'h0;
			tx_bit_q  <= 4'h0;
			tx_busy_q <= 1'b1;
			tx_lf_q   <= ~send_ctl & ~send_ack & (I_RSP_DATA == C_LF);
			if (send_ctl)
				xoff_sent_q <= need_xoff;
		end
		else if (tx_busy_q && tick)
		begin
			tx_cnt_q <= tx_cnt_q + 4'h1;
			if (tx_cnt_q == OVS_LAST)
			begin
				tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
				tx_bit_q <= tx_bit_q + 4'h1;
				if (tx_bit_q == FRAME_LAST)
					tx_busy_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// daisy-chain repeat
	// ----------------------------------------
	// downstream replies merge onto our line; the protocol keeps one talker
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			O_SECONDARY_SERIAL_OUT <= 1'b1;
			O_TXD                  <= 1'b1;
		end
		else
		begin
			O_SECONDARY_SERIAL_OUT <= rx_pin;
			O_TXD                  <= tx_sh_q[0] & sec_pin;
		end
	end
endmodule

// *** sim/rsfe_sva.sv ***
// port checker for the remote serial front end
`timescale 1ns/1ps
module rsfe_sva
	import rsfe_pkg::*;
(
	// clock and reset
	input wire logic              I_CORE_CLK,
	input wire logic              I_ARST_N,
	// serial pins
	input wire logic              I_RXD,
	input wire logic              O_TXD,
	input wire logic              I_SECONDARY_SERIAL_IN,
	input wire logic              O_SECONDARY_SERIAL_OUT,
	// configuration and panel
	input wire logic              I_IF_SERIAL,
	input wire logic [ADDR_W-1:0] I_DEV_ADDR,
	input wire logic              O_REMOTE_INDICATOR,
	input wire logic              O_KEYPAD_EN,
	input wire logic              O_ADDR_OK,
	// streams
	input wire logic              O_CMD_VALID,
	input wire logic [7:0]        O_CMD_DATA,
	input wire logic              I_CMD_READY,
	input wire logic              I_RSP_VALID,
	input wire logic              O_RSP_READY
);
	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (!I_ARST_N);

	// ----
	// sequences
	// ----
	sequence s_rsp_take;
		I_RSP_VALID && O_RSP_READY;
	endsequence
	// start bit lands two clocks after the take, ready stays low
	sequence s_start_bit;
		!O_RSP_READY ##1 (!O_RSP_READY && !O_TXD);
	endsequence

	AST_RESET_LOCAL: assert property ($rose(I_ARST_N) |-> !O_REMOTE_INDICATOR && O_KEYPAD_EN)
		else $error("not local after reset");
	AST_KEYPAD_LOCK: assert property (O_KEYPAD_EN == !O_REMOTE_INDICATOR)
		else $error("keypad enable disagrees with remote");
	AST_ADDR_CHECK: assert property (O_ADDR_OK == !(!I_IF_SERIAL && I_DEV_ADDR == PBUS_BAD))
		else $error("address status wrong");
	AST_CMD_MSB: assert property (O_CMD_VALID |-> !O_CMD_DATA[7])
		else $error("text bit 7 set");
	AST_CMD_PRINT: assert property (O_CMD_VALID |-> O_CMD_DATA >= PRINT_MIN)
		else $error("control code in text");
	AST_CMD_FOLD: assert property (O_CMD_VALID |-> !(O_CMD_DATA inside {[LOWER_A:LOWER_Z]}))
		else $error("lower case in text");
	AST_CMD_HOLD: assert property (O_CMD_VALID && !I_CMD_READY |=> O_CMD_VALID && $stable(O_CMD_DATA))
		else $error("text dropped while stalled");
	AST_REPEAT_DOWN: assert property (!I_RXD [*5] |-> !O_SECONDARY_SERIAL_OUT)
		else $error("upstream not repeated");
	AST_MERGE_UP: assert property (!I_SECONDARY_SERIAL_IN [*5] |-> !O_TXD)
		else $error("downstream not merged");
	AST_RSP_FRAME: assert property (s_rsp_take |=> s_start_bit)
		else $error("response start bit late");
endmodule

bind rsfe_top rsfe_sva chk_u (.I_CORE_CLK(I_CORE_CLK), .I_ARST_N(I_ARST_N), .I_RXD(I_RXD),
	.O_TXD(O_TXD), .I_SECONDARY_SERIAL_IN(I_SECONDARY_SERIAL_IN),
	.O_SECONDARY_SERIAL_OUT(O_SECONDARY_SERIAL_OUT), .I_IF_SERIAL(I_IF_SERIAL),
	.I_DEV_ADDR(I_DEV_ADDR), .O_REMOTE_INDICATOR(O_REMOTE_INDICATOR),
	.O_KEYPAD_EN(O_KEYPAD_EN), .O_ADDR_OK(O_ADDR_OK), .O_CMD_VALID(O_CMD_VALID),
	.O_CMD_DATA(O_CMD_DATA), .I_CMD_READY(I_CMD_READY), .I_RSP_VALID(I_RSP_VALID),
	.O_RSP_READY(O_RSP_READY));

// *** sim/rsfe_host.sv ***
// host controller model on the upstream serial pins
`timescale 1ns/1ps
module rsfe_host
	import rsfe_pkg::*;
#(
	parameter int BIT = 32
) (
	// clock
	input  wire logic i_clk,
	// serial pins
	output logic      o_txd,
	input  wire logic i_rxd
);
	logic [7:0] rx_q[$];
	logic [7:0] rx_b;
	logic       paused = 1'b0;
	int         stuck  = 0;

	initial
		o_txd = 1'b1;

	// start, eight data lsb first, stop
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int n = 0; n < 400 * BIT && paused; n++)
			@(negedge i_clk);
		if (paused)
			stuck++;
		@(negedge i_clk);
		for (int i = 0; i < 10; i++)
		begin
			o_txd <= f[i];
			repeat (BIT) @(negedge i_clk);
		end
	endtask

	// glitch shorter than half a bit is not a start
	always
	begin
		@(negedge i_rxd);
		repeat (BIT / 2) @(posedge i_clk);
		if (!i_rxd)
		begin
			for (int i = 0; i < 8; i++)
			begin
				repeat (BIT) @(posedge i_clk);
				rx_b[i] = i_rxd;
			end
			repeat (BIT) @(posedge i_clk);
			if (i_rxd)
			begin
				if (rx_b == C_XOFF)
					paused = 1'b1;
				if (rx_b == C_XON)
					paused = 1'b0;
				rx_q.push_back(rx_b);
			end
		end
	end
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the remote serial front end
`timescale 1ns/1ps
module testbench;
	import rsfe_pkg::*;
	localparam int DIV = 1;
	localparam int BIT = OVS * (DIV + 1);
	logic clk = 1'b0;
	logic arst_n, txd, rxd, sec_in, sec_out, if_ser, key, remote, kp_en, addr_ok, stall;
	logic cmd_valid, cmd_ready, cmd_end, rsp_valid, rsp_ready;
	logic [7:0] cmd_data, rsp_data, t;
	logic [4:0] dev_addr, addr;
	logic [7:0] exp_q[$];
	logic [31:0] r;
	integer seed;
	int fail_count, checks_done, exp_end, got_end;
	bit hear;

	always #5 clk = ~clk;

	rsfe_top dut_u (.I_CORE_CLK(clk), .I_ARST_N(arst_n), .I_RXD(rxd), .O_TXD(txd),
		.I_SECONDARY_SERIAL_IN(sec_in), .O_SECONDARY_SERIAL_OUT(sec_out),
		.I_IF_SERIAL(if_ser), .I_DEV_ADDR(dev_addr), .I_OVS_DIV(16'(DIV)),
		.I_LOCAL_KEY(key), .O_REMOTE_INDICATOR(remote), .O_KEYPAD_EN(kp_en),
		.O_ADDR_OK(addr_ok), .O_CMD_VALID(cmd_valid), .O_CMD_DATA(cmd_data),
		.I_CMD_READY(cmd_ready), .O_CMD_END(cmd_end), .I_RSP_VALID(rsp_valid),
		.I_RSP_DATA(rsp_data), .O_RSP_READY(rsp_ready));
	// a single unit on the chain stays far inside the unit limit
	rsfe_host #(.BIT(BIT)) host_u (.i_clk(clk), .o_txd(rxd), .i_rxd(txd));

	task automatic chk(input bit ok, input string m);
		checks_done++;
		if (!ok)
		begin
			fail_count++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task automatic summarize;
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic stop(input string m);
		chk(1'b0, m);
		summarize();
	endtask

	// reference: mask bit 7, drop controls, fold case, only while hearing
	task automatic put(input logic [7:0] c);
		t = c & MSB_CLEAR;
		if (hear && t >= PRINT_MIN)
			exp_q.push_back((t >= LOWER_A && t <= LOWER_Z) ? t - CASE_BIT : t);
		if (hear && t == C_LF)
			exp_end++;
		host_u.send(c);
	endtask
	task automatic drain;
		for (int i = 0; i < 30 * BIT && exp_q.size() > 0; i++)
			@(negedge clk);
		if (exp_q.size() > 0)
			stop("text stalled");
	endtask
	task automatic got(input logic [7:0] b, input string m);
		for (int i = 0; i < 30 * BIT && host_u.rx_q.size() == 0; i++)
			@(negedge clk);
		if (host_u.rx_q.size() == 0)
			stop("no serial reply");
		chk(host_u.rx_q.pop_front() === b, m);
	endtask
	task automatic rsp(input logic [7:0] b);
		rsp_data = b;
		rsp_valid = 1'b1;
		for (int i = 0; i < 20 * BIT && rsp_ready !== 1'b1; i++)
			@(negedge clk);
		if (rsp_ready !== 1'b1)
			stop("response refused");
		@(negedge clk);
		rsp_valid = 1'b0;
		@(negedge clk);
	endtask

	// text consumer: random stalls, compares every word taken
	always @(negedge clk)
		cmd_ready <= !stall & 1'($random(seed));
	always @(posedge clk)
	begin
		if (cmd_valid === 1'b1 && cmd_ready === 1'b1)
			chk(exp_q.size() > 0 && cmd_data === exp_q.pop_front(), "text char");
		if (cmd_end === 1'b1)
			got_end++;
	end

	initial
	begin
		seed = 32'h5CCF;
		{arst_n, key, stall, rsp_valid} = 4'h0;
		{sec_in, if_ser, hear} = 3'h7;
		rsp_data = 8'h00;
		r = $random(seed);
		addr = r[4:0];
		dev_addr = addr;
		repeat (4) @(posedge clk);
		@(negedge clk);
		arst_n = 1'b1;
		repeat (2) @(negedge clk);
		chk(remote === 1'b0 && kp_en === 1'b1, "reset state");
		$display("test reset done");
		// ----
		// non-addressable text
		// ----
		put(C_LISTEN);
		put(8'h40 | {3'h0, addr});
		for (int i = 0; i < 8; i++)
		begin
			r = $random(seed);
			put({r[7], 7'h00} | (8'h40 + {2'h0, r[5:0]}));
		end
		put(8'h05);
		put(C_LF);
		drain();
		chk(host_u.rx_q.size() == 0, "answered before 02H");
		chk(remote === 1'b1 && kp_en === 1'b0, "not remote");
		key = 1'b1;
		repeat (4) @(negedge clk);
		key = 1'b0;
		repeat (4) @(negedge clk);
		chk(remote === 1'b0 && kp_en === 1'b1, "local key");
		put(8'h71);
		drain();
		chk(remote === 1'b1, "remote again");
		$display("test text done");
		// ----
		// addressing, acknowledge, wrong address
		// ----
		put(C_SET_ADDR);
		hear = 1'b0;
		put(C_LISTEN);
		put(8'h40 | {3'h0, addr});
		hear = 1'b1;
		got(C_ACK, "listen ack");
		put(8'h7A);
		put(C_LF);
		drain();
		hear = 1'b0;
		put(C_LISTEN);
		put(8'h40 | {3'h0, addr ^ 5'h01});
		put(8'h6B);
		repeat (10 * BIT) @(negedge clk);
		chk(host_u.rx_q.size() == 0, "ack to wrong address");
		$display("test addressing done");
		// ----
		// flow control on a full buffer
		// ----
		put(C_LISTEN);
		put(8'h40 | {3'h0, addr});
		hear = 1'b1;
		got(C_ACK, "relisten ack");
		stall = 1'b1;
		put(8'h41);
		put(8'h42);
		got(C_XOFF, "xoff on full");
		stall = 1'b0;
		got(C_XON, "xon on empty");
		drain();
		$display("test flow done");
		// ----
		// talk, paused by xoff, response out
		// ----
		hear = 1'b0;
		put(C_TALK);
		put(8'h40 | {3'h0, addr});
		put(C_XOFF);
		rsp_data = 8'h52;
		rsp_valid = 1'b1;
		repeat (3 * BIT) @(negedge clk);
		chk(rsp_ready === 1'b0, "sent while paused");
		rsp_valid = 1'b0;
		put(C_XON);
		rsp(8'h52);
		rsp(C_LF);
		got(8'h52, "response char");
		got(C_LF, "response end");
		$display("test response done");
		// ----
		// address status, downstream merge, terminators
		// ----
		if_ser = 1'b0;
		put(C_LISTEN);
		put(8'h40 | {3'h0, addr});
		repeat (12 * BIT) @(negedge clk);
		chk(host_u.rx_q.size() == 0, "heard on parallel bus");
		dev_addr = PBUS_BAD;
		@(negedge clk);
		chk(addr_ok === 1'b0, "31 on parallel bus");
		if_ser = 1'b1;
		@(negedge clk);
		chk(addr_ok === 1'b1, "31 on serial");
		sec_in = 1'b0;
		repeat (8) @(negedge clk);
		chk(txd === 1'b0 && sec_out === 1'b1, "downstream merge");
		sec_in = 1'b1;
		chk(got_end == exp_end, "terminator count");
		chk(host_u.stuck == 0, "host held by xoff");
		$display("test status done");
		summarize();
	end
endmodule
